/* File: fault_record_pkg.sv */
package fault_record_pkg;

    // Bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // Printed object indexes; byte address is four times the index
    localparam logic [13:0] IDX_NEWEST = 14'h2a70;
    localparam logic [13:0] IDX_HIST_FIRST = 14'h2a71;
    localparam logic [13:0] IDX_HIST_LAST = 14'h2a7f;
    localparam logic [13:0] IDX_STATUS = 14'h2c02;
    localparam logic [13:0] IDX_ERASE = 14'h2c03;
    localparam logic [13:0] IDX_MODE = 14'h2c10;
    localparam logic [13:0] IDX_TRIGGER = 14'h2c11;
    localparam logic [13:0] IDX_SUBSEL = 14'h2c12;
    localparam logic [9:0] ARRAY_GROUP = 10'h2a7;

    // Subindexes of one record array
    localparam logic [2:0] SUB_COUNT = 3'h0;
    localparam logic [2:0] SUB_NUMBER = 3'h1;
    localparam logic [2:0] SUB_ALARM = 3'h2;
    localparam logic [2:0] SUB_PON_TIME = 3'h3;
    localparam logic [2:0] SUB_SECONDS = 3'h4;
    localparam logic [2:0] SUB_NANOSEC = 3'h5;
    localparam logic [2:0] SUB_TIME_ZONE = 3'h6;
    localparam logic [2:0] SUB_SUMMER = 3'h7;
    localparam logic [31:0] SUBINDEX_TOTAL = 32'h0000_0007;

    // History and numbering
    localparam int HISTORY_DEPTH = 16;
    localparam logic [13:0] RECNUM_MAX = 14'd9999;
    localparam logic [15:0] ERASE_KEY = 16'h1ea5;

    // Status layout
    localparam int STATUS_COUNT_LSB = 0;
    localparam int STATUS_STATE_LSB = 8;

    // Settings reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MODE_AUTOMATIC = 8'h00;
    localparam logic [31:0] TRIGGER_RESET = 32'h0000_0000;
    localparam logic [3:0] CHANNEL_SET_STANDARD = 4'h0;

    // Alarms that own a channel set; set id is list position plus one
    localparam int ALARM_SETS = 9;
    localparam logic [31:0] ALARM_LIST [ALARM_SETS] = '{
        32'h0000_0010, 32'h0000_0020, 32'h0000_0021, 32'h0000_0024, 32'h0000_0030,
        32'h0000_0031, 32'h0000_0032, 32'h0000_0033, 32'h0000_0035
    };

    // Responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {st_empty, st_holding, st_full} recorder_state_type;

endpackage

/* File: channel_select.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_select #(
    parameter int SETS = fault_record_pkg::ALARM_SETS
) (
    input wire logic [7:0] mode,
    input wire logic [31:0] trigger,
    output logic [3:0] set_id
);

    logic [3:0] part [SETS+1];

    if (SETS < 1 || SETS > 15) begin : g_bad_sets
        $error("channel_select: SETS must be 1 to 15");
    end

    assign part[0] = fault_record_pkg::CHANNEL_SET_STANDARD;

    ////////////////////////////////////////////////////////////////////////
    // per alarm match
    for (genvar i = 0; i < SETS; i++) begin : g_match
        assign part[i+1] = part[i] |
            ((trigger == fault_record_pkg::ALARM_LIST[i]) ? 4'(i + 1) : 4'h0);
    end

    // automatic mode selects; zero or unknown keeps standard
    assign set_id = (mode == fault_record_pkg::MODE_AUTOMATIC)
        ? part[SETS] : fault_record_pkg::CHANNEL_SET_STANDARD;

endmodule
`default_nettype wire

/* File: record_store.sv */
`timescale 1ns/1ps
`default_nettype none
module record_store #(
    parameter int DEPTH = fault_record_pkg::HISTORY_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic push,
    input wire logic clear,
    input wire logic [15:0] in_alarm,
    input wire logic [31:0] in_pon_time,
    input wire logic [31:0] in_seconds,
    input wire logic [31:0] in_nanosec,
    input wire logic [15:0] in_time_zone,
    input wire logic [15:0] in_summer,
    input wire logic [3:0] rd_entry,
    input wire logic [2:0] rd_sub,
    output logic [31:0] rd_data,
    output logic [4:0] stored_count
);

    logic [13:0] num_q [DEPTH];
    logic [15:0] alarm_q [DEPTH];
    logic [31:0] pon_q [DEPTH];
    logic [31:0] sec_q [DEPTH];
    logic [31:0] nsec_q [DEPTH];
    logic [15:0] tz_q [DEPTH];
    logic [15:0] dst_q [DEPTH];
    logic [DEPTH-1:0] valid_q;
    logic [13:0] recnum_q;
    logic [13:0] recnum_d;

    if (DEPTH < 2 || DEPTH > 16) begin : g_bad_depth
        $error("record_store: DEPTH must be 2 to 16");
    end

    ////////////////////////////////////////////////////////////////////////
    // wrap after the top number
    assign recnum_d = (recnum_q == fault_record_pkg::RECNUM_MAX) ? 14'd0 : recnum_q + 14'd1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            recnum_q <= 14'd0;
        end else if (push) begin
            recnum_q <= recnum_d;
        end
    end

    // shift older, newest at position zero
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        // Entry zero has no newer neighbour; keeps its index in range
        localparam int PREV = (i == 0) ? 0 : i - 1;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                valid_q[i] <= 1'b0;
                num_q[i] <= 14'd0;
                alarm_q[i] <= 16'h0000;
                pon_q[i] <= 32'h0000_0000;
                sec_q[i] <= 32'h0000_0000;
                nsec_q[i] <= 32'h0000_0000;
                tz_q[i] <= 16'h0000;
                dst_q[i] <= 16'h0000;
            end else if (push) begin
                if (i == 0) begin
                    valid_q[i] <= 1'b1;
                    num_q[i] <= recnum_q;
                    alarm_q[i] <= in_alarm;
                    pon_q[i] <= in_pon_time;
                    sec_q[i] <= in_seconds;
                    nsec_q[i] <= in_nanosec;
                    tz_q[i] <= in_time_zone;
                    dst_q[i] <= in_summer;
                end else begin
                    // a clear with a push keeps only the new record
                    valid_q[i] <= valid_q[PREV] & ~clear;
                    num_q[i] <= num_q[PREV];
                    alarm_q[i] <= alarm_q[PREV];
                    pon_q[i] <= pon_q[PREV];
                    sec_q[i] <= sec_q[PREV];
                    nsec_q[i] <= nsec_q[PREV];
                    tz_q[i] <= tz_q[PREV];
                    dst_q[i] <= dst_q[PREV];
                end
            end else if (clear) begin
                valid_q[i] <= 1'b0;
            end
        end
    end

    always_comb begin
        stored_count = 5'd0;
        for (int i = 0; i < DEPTH; i++) begin
            stored_count = stored_count + 5'(valid_q[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // subindex zero; fields; empty slots read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_sub == fault_record_pkg::SUB_COUNT) begin
            rd_data = fault_record_pkg::SUBINDEX_TOTAL;
        end else if (32'(rd_entry) < DEPTH && valid_q[rd_entry]) begin
            case (rd_sub)
                fault_record_pkg::SUB_NUMBER: rd_data = {18'h0, num_q[rd_entry]};
                fault_record_pkg::SUB_ALARM: rd_data = {16'h0, alarm_q[rd_entry]};
                fault_record_pkg::SUB_PON_TIME: rd_data = pon_q[rd_entry];
                fault_record_pkg::SUB_SECONDS: rd_data = sec_q[rd_entry];
                fault_record_pkg::SUB_NANOSEC: rd_data = nsec_q[rd_entry];
                fault_record_pkg::SUB_TIME_ZONE: rd_data = {16'h0, tz_q[rd_entry]};
                fault_record_pkg::SUB_SUMMER: rd_data = {16'h0, dst_q[rd_entry]};
                default: rd_data = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // number wraps to zero
    a_number_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        push && recnum_q == fault_record_pkg::RECNUM_MAX |=> recnum_q == 14'd0)
        else $error("record number did not wrap");
    a_history_shift: assert property (@(posedge aclk) disable iff (!aresetn)
        push |=> num_q[1] == $past(num_q[0]) && sec_q[1] == $past(sec_q[0]))
        else $error("history did not shift");
    a_newest_number: assert property (@(posedge aclk) disable iff (!aresetn)
        push |=> valid_q[0] && num_q[0] == $past(recnum_q))
        else $error("newest record number wrong");
    c_wrap_seen: cover property (@(posedge aclk) disable iff (!aresetn)
        push && recnum_q == fault_record_pkg::RECNUM_MAX);

endmodule
`default_nettype wire

/* File: fault_record_history_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module fault_record_history_bank (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture_valid,
    input wire logic [15:0] capture_alarm,
    input wire logic [31:0] capture_pon_time,
    input wire logic [31:0] capture_seconds,
    input wire logic [31:0] capture_nanosec,
    input wire logic [15:0] capture_time_zone,
    input wire logic [15:0] capture_summer,
    output logic [3:0] channel_set_id
);

    ////////////////////////////////////////////////////////////////////////
    // Write channel state
    logic awready_q;
    logic wready_q;
    logic aw_held_q;
    logic w_held_q;
    logic [13:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    // Read channel state
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    // Settings and status
    logic [7:0] mode_q;
    logic [31:0] trigger_q;
    logic [2:0] subsel_q;
    logic [3:0] set_id_q;
    fault_record_pkg::recorder_state_type state_q;
    fault_record_pkg::recorder_state_type state_d;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire aw_take = s_axi_awvalid && awready_q;
    wire w_take = s_axi_wvalid && wready_q;
    wire wr_do = aw_held_q && w_held_q && !bvalid_q;
    wire ar_take = s_axi_arvalid && arready_q;
    wire [13:0] ridx = s_axi_araddr[15:2];
    wire rd_array = ridx[13:4] == fault_record_pkg::ARRAY_GROUP;
    wire rd_status = ridx == fault_record_pkg::IDX_STATUS;
    wire rd_erase = ridx == fault_record_pkg::IDX_ERASE;
    wire rd_mode = ridx == fault_record_pkg::IDX_MODE;
    wire rd_trigger = ridx == fault_record_pkg::IDX_TRIGGER;
    wire rd_subsel = ridx == fault_record_pkg::IDX_SUBSEL;
    wire rd_hit = rd_array | rd_status | rd_erase | rd_mode | rd_trigger | rd_subsel;
    wire wr_erase = waddr_q == fault_record_pkg::IDX_ERASE;
    wire wr_mode = waddr_q == fault_record_pkg::IDX_MODE;
    wire wr_trigger = waddr_q == fault_record_pkg::IDX_TRIGGER;
    wire wr_subsel = waddr_q == fault_record_pkg::IDX_SUBSEL;
    wire wr_hit = wr_erase | wr_mode | wr_trigger | wr_subsel;
    // key with both low lanes; anything else does nothing
    wire key_ok = wdata_q[15:0] == fault_record_pkg::ERASE_KEY && wstrb_q[1:0] == 2'b11;
    wire clear_hist = wr_do && wr_erase && key_ok;
    wire [31:0] store_data;
    wire [4:0] stored_count;
    wire [3:0] sel_id;
    wire [15:0] status_word;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // entry taken from low index bits, newest at the base
    record_store #(
        .DEPTH(fault_record_pkg::HISTORY_DEPTH)
    ) u_store (
        .aclk(aclk),
        .aresetn(aresetn),
        .push(capture_valid),
        .clear(clear_hist),
        .in_alarm(capture_alarm),
        .in_pon_time(capture_pon_time),
        .in_seconds(capture_seconds),
        .in_nanosec(capture_nanosec),
        .in_time_zone(capture_time_zone),
        .in_summer(capture_summer),
        .rd_entry(ridx[3:0]),
        .rd_sub(subsel_q),
        .rd_data(store_data),
        .stored_count(stored_count)
    );

    channel_select #(
        .SETS(fault_record_pkg::ALARM_SETS)
    ) u_select (
        .mode(mode_q),
        .trigger(trigger_q),
        .set_id(sel_id)
    );

    ////////////////////////////////////////////////////////////////////////
    // state follows the fill level of the history
    always_comb begin
        state_d = fault_record_pkg::st_holding;
        if (stored_count == 5'd0) begin
            state_d = fault_record_pkg::st_empty;
        end else if (32'(stored_count) == fault_record_pkg::HISTORY_DEPTH) begin
            state_d = fault_record_pkg::st_full;
        end
    end

    assign status_word = (16'(stored_count) << fault_record_pkg::STATUS_COUNT_LSB)
        | (16'(state_q) << fault_record_pkg::STATUS_STATE_LSB);

    // clear object and the unmapped space read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (rd_array) begin
            rd_mux = store_data;
        end else if (rd_status) begin
            rd_mux = {16'h0000, status_word};
        end else if (rd_mode) begin
            rd_mux = {24'h0, mode_q};
        end else if (rd_trigger) begin
            rd_mux = trigger_q;
        end else if (rd_subsel) begin
            rd_mux = {29'h0, subsel_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write path: address and data in either order, answer after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            waddr_q <= 14'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= fault_record_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                awready_q <= 1'b0;
                aw_held_q <= 1'b1;
                waddr_q <= s_axi_awaddr[15:2];
            end
            if (w_take) begin
                wready_q <= 1'b0;
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? fault_record_pkg::RESP_OKAY : fault_record_pkg::RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Settings honour byte lanes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= fault_record_pkg::MODE_RESET;
            trigger_q <= fault_record_pkg::TRIGGER_RESET;
            subsel_q <= fault_record_pkg::SUB_COUNT;
        end else if (wr_do) begin
            if (wr_mode && wstrb_q[0]) begin
                mode_q <= wdata_q[7:0];
            end
            if (wr_subsel && wstrb_q[0]) begin
                subsel_q <= wdata_q[2:0];
            end
            if (wr_trigger) begin
                for (int b = 0; b < 4; b++) begin
                    if (wstrb_q[b]) begin
                        trigger_q[8*b +: 8] <= wdata_q[8*b +: 8];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: data registered on the same edge that takes the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= fault_record_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? fault_record_pkg::RESP_OKAY : fault_record_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Status and channel set are registered so outputs come from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= fault_record_pkg::st_empty;
            set_id_q <= fault_record_pkg::CHANNEL_SET_STANDARD;
        end else begin
            state_q <= state_d;
            set_id_q <= sel_id;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign channel_set_id = set_id_q;

    ////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && rd_status |=> rvalid_q && rdata_q[4:0] == $past(stored_count))
        else $error("status read wrong");
    a_erase_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && rd_erase |=> rvalid_q && rdata_q == 32'h0000_0000)
        else $error("clear object read not zero");
    a_sub_zero_count: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && rd_array && subsel_q == fault_record_pkg::SUB_COUNT
        |=> rdata_q == fault_record_pkg::SUBINDEX_TOTAL)
        else $error("subindex count wrong");
    a_key_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        clear_hist && !capture_valid
        |=> stored_count == 5'd0 ##1 state_q == fault_record_pkg::st_empty)
        else $error("history not cleared");
    a_bad_key_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_do && wr_erase && !key_ok && !capture_valid |=> $stable(stored_count))
        else $error("wrong key changed history");
    a_standard_set: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == fault_record_pkg::MODE_AUTOMATIC && trigger_q == 32'h0 && $stable(trigger_q)
        |=> channel_set_id == fault_record_pkg::CHANNEL_SET_STANDARD)
        else $error("standard set not chosen");
    a_alarm_set: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_q == fault_record_pkg::MODE_AUTOMATIC
        && trigger_q == fault_record_pkg::ALARM_LIST[4] |=> channel_set_id == 4'h5)
        else $error("alarm set not chosen");
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        aw_take && w_take |=> ##1 bvalid_q)
        else $error("write answer late");
    c_clear_seen: cover property (@(posedge aclk) disable iff (!aresetn) clear_hist);
    c_full_seen: cover property (@(posedge aclk) disable iff (!aresetn)
        state_q == fault_record_pkg::st_full);
    c_array_read: cover property (@(posedge aclk) disable iff (!aresetn)
        ar_take && rd_array && subsel_q == fault_record_pkg::SUB_SECONDS);

endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, capture_pon_time, capture_seconds, capture_nanosec;
    logic [3:0] s_axi_wstrb, channel_set_id;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, capture_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] capture_alarm, capture_time_zone, capture_summer;
    int failures = 0;
    int n_tests = 0;
    logic [31:0] d;
    logic [1:0] r;
    fault_record_history_bank dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .capture_valid, .capture_alarm, .capture_pon_time,
        .capture_seconds, .capture_nanosec, .capture_time_zone, .capture_summer, .channel_set_id);
    always #2.5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Both channels offered together; each released once taken
    task automatic wr(input logic [13:0] idx, input logic [31:0] data);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [13:0] idx, output logic [31:0] data, output logic [1:0] resp);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Field values derived from the alarm so records with different alarms differ in every field
    function automatic logic [31:0] field(input logic [15:0] a, input int s);
        case (s)
            2: field = {16'h0000, a};
            3: field = {16'h1000, a};
            4: field = {16'h6000, a};
            5: field = {16'h0bad, a};
            6: field = {16'h0000, a ^ 16'h0009};
            default: field = {16'h0000, a ^ 16'h0001};
        endcase
    endfunction
    task automatic cap(input logic [15:0] a, input int n);
        capture_alarm <= a;
        capture_pon_time <= field(a, 3);
        capture_seconds <= field(a, 4);
        capture_nanosec <= field(a, 5);
        capture_time_zone <= 16'(field(a, 6));
        capture_summer <= 16'(field(a, 7));
        capture_valid <= 1'b1;
        repeat (n) @(posedge aclk);
        capture_valid <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic sub(input logic [13:0] idx, input int s, input logic [31:0] exp, string w);
        wr(fault_record_pkg::IDX_SUBSEL, s);
        rd(idx, d, r);
        check(d, exp, w);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_erase_and_count();
        wr(fault_record_pkg::IDX_ERASE, 32'h0000_1234);
        check({30'h0, r}, {30'h0, fault_record_pkg::RESP_OKAY}, "erase write resp");
        rd(fault_record_pkg::IDX_ERASE, d, r);
        check(d, 32'h0000_0000, "erase readback");
        sub(fault_record_pkg::IDX_NEWEST, 0, 32'h0000_0007, "newest count");
        sub(fault_record_pkg::IDX_HIST_LAST, 0, 32'h0000_0007, "last count");
    endtask
    task automatic t_fields();
        cap(16'h0020, 1);
        cap(16'h0031, 1);
        sub(fault_record_pkg::IDX_NEWEST, 1, 32'h0000_0001, "newest number");
        for (int s = 2; s < 8; s++) begin
            sub(fault_record_pkg::IDX_NEWEST, s, field(16'h0031, s), "new");
        end
        sub(fault_record_pkg::IDX_HIST_FIRST, 1, 32'h0000_0000, "hist1 number");
        for (int s = 2; s < 8; s++) begin
            sub(fault_record_pkg::IDX_HIST_FIRST, s, field(16'h0020, s), "h1");
        end
    endtask
    task automatic t_clear();
        wr(fault_record_pkg::IDX_ERASE, 32'h0000_1ea4);
        sub(fault_record_pkg::IDX_HIST_FIRST, 2, 32'h0000_0020, "kept after bad key");
        wr(fault_record_pkg::IDX_ERASE, 32'h0000_1ea5);
        sub(fault_record_pkg::IDX_NEWEST, 2, 32'h0000_0000, "newest cleared");
        sub(fault_record_pkg::IDX_HIST_FIRST, 2, 32'h0000_0000, "hist1 cleared");
        rd(fault_record_pkg::IDX_STATUS, d, r);
        check({27'h0, d[4:0]}, 32'h0000_0000, "status count empty");
    endtask
    task automatic t_channels();
        repeat (2) @(posedge aclk);
        check({28'h0, channel_set_id}, 32'h0000_0000, "standard set");
        for (int i = 0; i < fault_record_pkg::ALARM_SETS; i++) begin
            wr(fault_record_pkg::IDX_TRIGGER, fault_record_pkg::ALARM_LIST[i]);
            repeat (2) @(posedge aclk);
            check({28'h0, channel_set_id}, i + 1, "alarm set");
        end
        wr(fault_record_pkg::IDX_MODE, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        check({28'h0, channel_set_id}, 32'h0000_0000, "manual mode set");
        wr(fault_record_pkg::IDX_TRIGGER, 32'h0000_0000);
        wr(fault_record_pkg::IDX_MODE, 32'h0000_0000);
    endtask
    // Numbering continues through a clear: next is 2, so 9998 more reach 9999
    task automatic t_wrap();
        cap(16'h0010, 9998);
        sub(fault_record_pkg::IDX_NEWEST, 1, 32'd9999, "number at top");
        cap(16'h0035, 1);
        sub(fault_record_pkg::IDX_NEWEST, 1, 32'd0, "number wrapped");
        sub(fault_record_pkg::IDX_HIST_FIRST, 1, 32'd9999, "older number");
        rd(fault_record_pkg::IDX_STATUS, d, r);
        check({22'h0, d[9:0]}, 32'h0000_0210, "status full");
        check({30'h0, r}, {30'h0, fault_record_pkg::RESP_OKAY}, "status resp");
        wr(fault_record_pkg::IDX_NEWEST, 32'h0000_0000);
        check({30'h0, r}, {30'h0, fault_record_pkg::RESP_SLVERR}, "array write resp");
        rd(14'h0001, d, r);
        check({30'h0, r}, {30'h0, fault_record_pkg::RESP_SLVERR}, "unmapped resp");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        {capture_valid, capture_alarm, capture_pon_time, capture_seconds} = '0;
        {capture_nanosec, capture_time_zone, capture_summer} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_erase_and_count();
        t_fields();
        t_clear();
        t_channels();
        t_wrap();
        end_of_test();
    end
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
endmodule
`default_nettype wire
